// ==== core/ddsc_map.vh ====
// Register map and timing constants for the disk drive status control block
`ifndef DDSC_MAP_VH
`define DDSC_MAP_VH
`define DDSC_CLK_HZ        10000000
`define DDSC_SPINUP_MS     500
`define DDSC_SPINUP_CYC    (`DDSC_CLK_HZ / 1000 * `DDSC_SPINUP_MS)
`define DDSC_SPINUP_W      23
`define DDSC_SPIN_INIT     23'h000000
`define DDSC_ADDR_W        5
`define DDSC_ADDR_CTRL     5'h00
`define DDSC_ADDR_STAT     5'h04
`define DDSC_ADDR_IRQ      5'h08
`define DDSC_ADDR_MASK     5'h0C
`define DDSC_ADDR_SENSE    5'h10
`define DDSC_CTRL_UNIT_LO  0
`define DDSC_CTRL_UNIT_HI  1
`define DDSC_CTRL_TWOSIDE  2
`define DDSC_CTRL_RDYOPT   3
`define DDSC_CTRL_RESET    4'h4
`define DDSC_IRQ_INDEX     0
`define DDSC_IRQ_TRK00     1
`define DDSC_IRQ_READY     2
`define DDSC_IRQ_LOCK      3
`define DDSC_IRQ_W         4
`define DDSC_IRQ_ZERO      4'h0
`define DDSC_RESP_OKAY     2'h0
`define DDSC_RESP_SLVERR   2'h2
`endif

// ==== core/ddsc_sync.v ====
// Three-stage input synchroniser with agreement qualification
`timescale 1ns/1ps
`default_nettype none
module ddsc_sync (
  // Clock and reset
  input  wire clock_i,
  input  wire resetn_i,
  // Raw input and resolved level
  input  wire din_i,
  output reg  dout_o
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1     <= 1'b1;
      s2     <= 1'b1;
      s3     <= 1'b1;
      dout_o <= 1'b1;
    end else begin
      s1 <= din_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout_o <= s3;
      end
    end
  end
endmodule
`default_nettype wire

// ==== core/ddsc_top.v ====
// Drive-side spindle, head engage and status line logic with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "ddsc_map.vh"
// What this block does
// - Spindle turns while run request low
// - Spindle request ignores unit pick line
// - Engage needs request, turning media, ready low
// - Engage only two-sided, never without media
// - Index output low on index hole
// - Outer track flag low at track 00
// - Lock output low when notch covered
// - Optional ready low while disk turns
// - Ready goes busy-to-ready on index detection
// - Only picked drive engages head and drives status lines
module ddsc_top (
  // Clock and reset
  input  wire        clock_i,
  input  wire        resetn_i,
  // Host interface lines, active low, with active-high output enables
  input  wire [3:0]  unit_pick_n_i,
  input  wire        spin_req_n_i,
  input  wire        engage_req_n_i,
  output reg         index_n_o,
  output reg         index_n_oe_o,
  output reg         outer_trk_n_o,
  output reg         outer_trk_n_oe_o,
  output reg         media_lock_n_o,
  output reg         media_lock_n_oe_o,
  output reg         ready_n_o,
  output reg         ready_n_oe_o,
  // Drive mechanics
  input  wire        index_sense_n_i,
  input  wire        trk00_sense_n_i,
  input  wire        notch_covered_i,
  input  wire        media_present_i,
  output reg         spindle_on_o,
  output reg         head_engaged_o,
  // AXI4-Lite slave
  input  wire [4:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [4:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Interrupt
  output wire        irq_o
);
  // Synchronised sensor and host inputs
  wire       idx_s;
  wire       trk_s;
  wire       notch_s;
  wire       media_s;
  wire       spin_s;
  wire       eng_s;
  wire [3:0] pick_s;
  ddsc_sync u_idx (.clock_i(clock_i), .resetn_i(resetn_i),
    .din_i(index_sense_n_i), .dout_o(idx_s));
  ddsc_sync u_trk (.clock_i(clock_i), .resetn_i(resetn_i),
    .din_i(trk00_sense_n_i), .dout_o(trk_s));
  ddsc_sync u_notch (.clock_i(clock_i), .resetn_i(resetn_i),
    .din_i(~notch_covered_i), .dout_o(notch_s));
  ddsc_sync u_media (.clock_i(clock_i), .resetn_i(resetn_i),
    .din_i(~media_present_i), .dout_o(media_s));
  ddsc_sync u_spin (.clock_i(clock_i), .resetn_i(resetn_i),
    .din_i(spin_req_n_i), .dout_o(spin_s));
  ddsc_sync u_eng (.clock_i(clock_i), .resetn_i(resetn_i),
    .din_i(engage_req_n_i), .dout_o(eng_s));
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pick
      ddsc_sync u_pick (.clock_i(clock_i), .resetn_i(resetn_i),
        .din_i(unit_pick_n_i[gi]), .dout_o(pick_s[gi]));
    end
  endgenerate

  // Control register
  reg [3:0] ctrl;
  wire [1:0] unit_num = ctrl[`DDSC_CTRL_UNIT_HI:`DDSC_CTRL_UNIT_LO];
  wire       two_side = ctrl[`DDSC_CTRL_TWOSIDE];
  wire       rdy_opt  = ctrl[`DDSC_CTRL_RDYOPT];
  wire       picked   = ~pick_s[unit_num];
  wire       present  = ~media_s;

  // Spindle and spin-up counter
  reg [`DDSC_SPINUP_W-1:0] spin_cnt;
  reg                      idx_prev;
  reg                      rdy_int_n;
  wire                     idx_fall = idx_prev & ~idx_s;
  wire                     turning  = spindle_on_o & present &
                                      (spin_cnt == `DDSC_SPINUP_CYC);
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      spindle_on_o <= 1'b0;
      spin_cnt     <= `DDSC_SPIN_INIT;
      idx_prev     <= 1'b1;
      rdy_int_n    <= 1'b1;
    end else begin
      spindle_on_o <= ~spin_s;
      idx_prev     <= idx_s;
      if (spin_s || !present) begin
        spin_cnt <= `DDSC_SPIN_INIT;
      end else if (spin_cnt != `DDSC_SPINUP_CYC) begin
        spin_cnt <= spin_cnt + 1'b1;
      end
      if (!turning) begin
        rdy_int_n <= 1'b1;
      end else if (idx_fall) begin
        rdy_int_n <= 1'b0;
      end
    end
  end

  // Head engage and host outputs
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      head_engaged_o    <= 1'b0;
      index_n_o         <= 1'b1;
      index_n_oe_o      <= 1'b0;
      outer_trk_n_o     <= 1'b1;
      outer_trk_n_oe_o  <= 1'b0;
      media_lock_n_o    <= 1'b1;
      media_lock_n_oe_o <= 1'b0;
      ready_n_o         <= 1'b1;
      ready_n_oe_o      <= 1'b0;
    end else begin
      head_engaged_o <= picked & ~eng_s & turning & ~rdy_int_n
                        & two_side & present;
      index_n_o         <= idx_s;
      index_n_oe_o      <= picked;
      outer_trk_n_o     <= trk_s;
      outer_trk_n_oe_o  <= picked;
      media_lock_n_o    <= notch_s;
      media_lock_n_oe_o <= picked;
      ready_n_o         <= rdy_int_n;
      ready_n_oe_o      <= picked & rdy_opt;
    end
  end

  // Sticky events: index hole, track 00 reached, ready, lock change
  reg         trk_prev;
  reg         rdy_prev;
  reg         lock_prev;
  reg  [3:0]  irq_stat;
  reg  [3:0]  irq_mask;
  wire [3:0]  ev;
  assign ev[`DDSC_IRQ_INDEX] = idx_fall;
  assign ev[`DDSC_IRQ_TRK00] = trk_prev & ~trk_s;
  assign ev[`DDSC_IRQ_READY] = rdy_prev & ~rdy_int_n;
  assign ev[`DDSC_IRQ_LOCK]  = lock_prev ^ notch_s;
  assign irq_o = |(irq_stat & irq_mask);

  // AXI4-Lite write path
  reg        aw_held;
  reg        w_held;
  reg [4:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  wire aw_now = aw_held | s_axi_awvalid;
  wire w_now  = w_held | s_axi_wvalid;
  wire [4:0]  wa = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_held ? w_data : s_axi_wdata;
  wire [3:0]  ws = w_held ? w_strb : s_axi_wstrb;
  wire do_wr = aw_now & w_now & ~s_axi_bvalid;
  wire [3:0] next_ctrl = (do_wr && wa == `DDSC_ADDR_CTRL && ws[0]) ? wd[3:0] : ctrl;
  wire [3:0] next_mask = (do_wr && wa == `DDSC_ADDR_MASK && ws[0]) ? wd[3:0] : irq_mask;

  // AXI4-Lite read path
  assign s_axi_arready = ~s_axi_rvalid;
  wire do_rd   = s_axi_arvalid & ~s_axi_rvalid;
  wire rd_irq  = do_rd & (s_axi_araddr == `DDSC_ADDR_IRQ);
  reg  [31:0] rd_val;
  reg         rd_ok;
  always @* begin
    rd_val = 32'h00000000;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      `DDSC_ADDR_CTRL:  rd_val = {28'h0000000, ctrl};
      `DDSC_ADDR_STAT:  rd_val = {24'h000000, picked, head_engaged_o, turning,
                                  rdy_int_n, notch_s, trk_s, idx_s, spindle_on_o};
      `DDSC_ADDR_IRQ:   rd_val = {28'h0000000, irq_stat};
      `DDSC_ADDR_MASK:  rd_val = {28'h0000000, irq_mask};
      `DDSC_ADDR_SENSE: rd_val = {24'h000000, pick_s, eng_s, spin_s, media_s, 1'b0};
      default:          rd_ok  = 1'b0;
    endcase
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl         <= `DDSC_CTRL_RESET;
      irq_mask     <= `DDSC_IRQ_ZERO;
      irq_stat     <= `DDSC_IRQ_ZERO;
      trk_prev     <= 1'b1;
      rdy_prev     <= 1'b1;
      lock_prev    <= 1'b1;
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 5'h00;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DDSC_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `DDSC_RESP_OKAY;
    end else begin
      trk_prev  <= trk_s;
      rdy_prev  <= rdy_int_n;
      lock_prev <= notch_s;
      // Set wins over read clear
      irq_stat <= (rd_irq ? `DDSC_IRQ_ZERO : irq_stat) | ev;
      ctrl     <= next_ctrl;
      irq_mask <= next_mask;
      if (do_wr) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wa == `DDSC_ADDR_CTRL || wa == `DDSC_ADDR_MASK) ?
                        `DDSC_RESP_OKAY : `DDSC_RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
      if (do_rd) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_ok ? `DDSC_RESP_OKAY : `DDSC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/ddsc_host_model.sv ====
// Host controller model driving pick, motor and engage lines
`timescale 1ns/1ps
`default_nettype none
module ddsc_host_model (
  // Clock and commands
  input  wire logic       clock_i,
  input  wire logic       sel_i,
  input  wire logic [1:0] unit_i,
  input  wire logic       motor_i,
  input  wire logic       engage_i,
  // Drive status lines
  input  wire logic [3:0] line_i,
  input  wire logic [3:0] line_oe_i,
  // Lines to the drive, resolved status
  output var  logic [3:0] unit_pick_n_o,
  output var  logic       spin_req_n_o,
  output var  logic       engage_req_n_o,
  output wire logic [3:0] status_o
);
  // Released lines float high on the pull-up
  assign status_o = ~line_oe_i | line_i;
  initial begin
    unit_pick_n_o = 4'hF;
    spin_req_n_o = 1'b1;
    engage_req_n_o = 1'b1;
  end
  always @(posedge clock_i) begin
    unit_pick_n_o <= sel_i ? ~(4'h1 << unit_i) : 4'hF;
    spin_req_n_o <= ~motor_i;
    // Never reads or writes media, so no spin-up wait is owed
    engage_req_n_o <= ~engage_i;
  end
endmodule
`default_nettype wire

// ==== verification/ddsc_top_assertions.sv ====
// Port-level checks for the drive status control block
`timescale 1ns/1ps
`default_nettype none
module ddsc_checker (
  // Clock and reset
  input wire logic       clock_i,
  input wire logic       resetn_i,
  // Host and sensor inputs
  input wire logic [3:0] unit_pick_n_i,
  input wire logic       spin_req_n_i,
  input wire logic       index_sense_n_i,
  input wire logic       trk00_sense_n_i,
  input wire logic       notch_covered_i,
  input wire logic       media_present_i,
  // Outputs
  input wire logic       index_n_o,
  input wire logic       index_n_oe_o,
  input wire logic       outer_trk_n_o,
  input wire logic       media_lock_n_o,
  input wire logic       ready_n_oe_o,
  input wire logic       spindle_on_o,
  input wire logic       head_engaged_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  property p_spin; $stable(spin_req_n_i) [*7] |-> spindle_on_o != spin_req_n_i; endproperty
  a_spin: assert property (p_spin) else $error("spindle mismatch");
  property p_idx; $stable(index_sense_n_i) [*7] |-> index_n_o == index_sense_n_i; endproperty
  a_idx: assert property (p_idx) else $error("index mismatch");
  property p_trk; $stable(trk00_sense_n_i) [*7] |-> outer_trk_n_o == trk00_sense_n_i; endproperty
  a_trk: assert property (p_trk) else $error("track flag mismatch");
  property p_lock; $stable(notch_covered_i) [*7] |-> media_lock_n_o != notch_covered_i; endproperty
  a_lock: assert property (p_lock) else $error("lock mismatch");
  property p_oe; (unit_pick_n_i == 4'hF) [*7] |-> !index_n_oe_o && !ready_n_oe_o; endproperty
  a_oe: assert property (p_oe) else $error("driving while unpicked");
  property p_rdy; ready_n_oe_o |-> index_n_oe_o; endproperty
  a_rdy: assert property (p_rdy) else $error("ready driven unpicked");
  property p_media; !media_present_i [*7] |-> !head_engaged_o; endproperty
  a_media: assert property (p_media) else $error("engaged without media");
  property p_eng; spin_req_n_i [*7] |-> !head_engaged_o; endproperty
  a_eng: assert property (p_eng) else $error("engaged while stopped");
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the drive status control block
`timescale 1ns/1ps
`default_nettype none
`include "ddsc_map.vh"
module tb_top;
  logic clock_i, resetn_i, index_sense_n_i, trk00_sense_n_i, notch_covered_i, media_present_i;
  logic sel, motor, eng, spin_req_n_i, engage_req_n_i, spindle_on_o, head_engaged_o, irq_o;
  logic index_n_o, index_n_oe_o, outer_trk_n_o, outer_trk_n_oe_o;
  logic media_lock_n_o, media_lock_n_oe_o, ready_n_o, ready_n_oe_o;
  logic [1:0] unit, s_axi_bresp, s_axi_rresp;
  logic [3:0] unit_pick_n_i, status, s_axi_wstrb;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int fails, checks;
  ddsc_top DUT (.clock_i, .resetn_i, .unit_pick_n_i, .spin_req_n_i, .engage_req_n_i,
    .index_n_o, .index_n_oe_o, .outer_trk_n_o, .outer_trk_n_oe_o, .media_lock_n_o,
    .media_lock_n_oe_o, .ready_n_o, .ready_n_oe_o, .index_sense_n_i, .trk00_sense_n_i,
    .notch_covered_i, .media_present_i, .spindle_on_o, .head_engaged_o, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_o);
  ddsc_host_model u_host (.clock_i, .sel_i(sel), .unit_i(unit), .motor_i(motor),
    .engage_i(eng), .line_i({ready_n_o, media_lock_n_o, outer_trk_n_o, index_n_o}),
    .line_oe_i({ready_n_oe_o, media_lock_n_oe_o, outer_trk_n_oe_o, index_n_oe_o}),
    .unit_pick_n_o(unit_pick_n_i), .spin_req_n_o(spin_req_n_i),
    .engage_req_n_o(engage_req_n_i), .status_o(status));
  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bound(inout int n);
    n++;
    if (n > 100) begin
      fails++;
      print_verdict();
    end
  endtask
  task automatic axw(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      bound(n);
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask
  task automatic axr(input logic [4:0] a, input logic [31:0] m, e, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      bound(n);
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & m, e);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  initial begin
    {resetn_i, notch_covered_i, media_present_i, motor, eng, unit} = '0;
    {index_sense_n_i, trk00_sense_n_i, sel, s_axi_wstrb} = 7'h7F;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    fails = 0;
    checks = 0;
    repeat (16) @(posedge clock_i);
    resetn_i <= 1'b1;
    axr(`DDSC_ADDR_CTRL, 32'hF, 32'h4, `DDSC_RESP_OKAY);
    axr(`DDSC_ADDR_IRQ, 32'hF, 32'h0, `DDSC_RESP_OKAY);
    axr(5'h14, 32'hFFFFFFFF, 32'h0, `DDSC_RESP_SLVERR);
    axw(`DDSC_ADDR_STAT, 32'h0, `DDSC_RESP_SLVERR);
    axw(`DDSC_ADDR_MASK, 32'h1, `DDSC_RESP_OKAY);
    for (int k = 0; k < 3; k++) begin
      {notch_covered_i, trk00_sense_n_i, index_sense_n_i} <= 3'b011 ^ (3'b001 << k);
      repeat (8) @(posedge clock_i);
      chk({29'h0, status[2:0]}, {29'h0, 3'b111 ^ (3'b001 << k)});
      {notch_covered_i, trk00_sense_n_i, index_sense_n_i} <= 3'b011;
      repeat (8) @(posedge clock_i);
      chk({29'h0, status[2:0]}, 32'h7);
    end
    chk({31'h0, irq_o}, 32'h1);
    axr(`DDSC_ADDR_IRQ, 32'hF, 32'hB, `DDSC_RESP_OKAY);
    axw(`DDSC_ADDR_MASK, 32'h0, `DDSC_RESP_OKAY);
    chk({31'h0, irq_o}, 32'h0);
    unit <= 2'h1;
    index_sense_n_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    chk({28'h0, status}, 32'hF);
    chk({31'h0, irq_o}, 32'h0);
    axr(`DDSC_ADDR_IRQ, 32'h1, 32'h1, `DDSC_RESP_OKAY);
    axw(`DDSC_ADDR_CTRL, 32'hD, `DDSC_RESP_OKAY);
    repeat (2) @(posedge clock_i);
    chk({28'h0, status}, 32'hE);
    chk({31'h0, ready_n_oe_o}, 32'h1);
    sel <= 1'b0;
    motor <= 1'b1;
    media_present_i <= 1'b1;
    eng <= 1'b1;
    repeat (8) @(posedge clock_i);
    chk({31'h0, spindle_on_o}, 32'h1);
    chk({31'h0, head_engaged_o}, 32'h0);
    chk({28'h0, status}, 32'hF);
    axr(`DDSC_ADDR_STAT, 32'hFF, 32'h1D, `DDSC_RESP_OKAY);
    axr(`DDSC_ADDR_SENSE, 32'hFF, 32'hF0, `DDSC_RESP_OKAY);
    motor <= 1'b0;
    repeat (8) @(posedge clock_i);
    chk({31'h0, spindle_on_o}, 32'h0);
    print_verdict();
  end
endmodule
bind ddsc_top ddsc_checker u_chk (.clock_i, .resetn_i, .unit_pick_n_i, .spin_req_n_i,
  .index_sense_n_i, .trk00_sense_n_i, .notch_covered_i, .media_present_i, .index_n_o,
  .index_n_oe_o, .outer_trk_n_o, .media_lock_n_o, .ready_n_oe_o, .spindle_on_o,
  .head_engaged_o);
`default_nettype wire
